/* common/lfpax_defs.svh */
/*
 Constants of the load-flags, block-pointer and load-absolute execution block:
 register offsets, field positions, reset values and fixed codes.
 Assumes inclusion by bare name, after which the design uses the macros.
*/
// Behaviour
// - Byte bits 0-3 to flags if bit 10
// - Sum bits 29-31 to float modes if bit 11
// - R-field bits 10/11 qualify flag loads
// - Then final phase, set data-request interlock
// - Immediate value field to flags if bit 10
// - Immediate low bits to float modes if bit 11
// - Preparation sets memory request flag
// - First phase passes data through adder
// - Word bits 24-27 into block pointer
// - Pointer shows as status bits 56-59
// - Absent register block reads all ones
// - Halfword sign-extended, absolute value to R
// - Absolute result flags: zero 00, else 10
// - Word or its complement written to R
// - Most negative word flags overflow
// - Overflow with mask traps to 0x43
// - Word overflow sets flag 2
// - Preparation stores operand polarity flag
// - Program address through sum to counter
// - Adder preset pass or negate by sign
// - First phase sets write flag, request
// - Second phase writes R, flags 3/4
`ifndef LFPAX_DEFS_SVH
`define LFPAX_DEFS_SVH

// Register offsets
`define LFPAX_REG_STATUS    4'h0
`define LFPAX_REG_CTRL      4'h4
`define LFPAX_REG_SUM       4'h8

// Control register fields
`define LFPAX_CTRL_MASK_BIT 0
`define LFPAX_CTRL_BLK_LSB  4
`define LFPAX_CTRL_BLK_MSB  8

// Reset values
`define LFPAX_RST_BLOCKS    5'h10
`define LFPAX_RST_MASK      1'h0

// Instruction R-field bits (little-endian index within the 4-bit field)
`define LFPAX_RF_BIT10      1
`define LFPAX_RF_BIT11      0

// Sum bus fields, big-endian bits 24-27 and 29-31
`define LFPAX_S24_27_MSB    7
`define LFPAX_S24_27_LSB    4
`define LFPAX_S29           2
`define LFPAX_S30           1
`define LFPAX_S31           0

// Pointer position in the low status word (bits 56-59)
`define LFPAX_PSD_RP_LSB    4

// Fixed codes
`define LFPAX_TRAP_VECTOR   8'h43
`define LFPAX_MOST_NEG      32'h80000000
`define LFPAX_ALL_ONES      32'hffffffff

`endif

/* common/lfpax_pkg.sv */
/*
 Types of the load-flags, block-pointer and load-absolute execution block.
 Assumes lfpax_defs.svh supplies the numeric constants.
*/
package lfpax_pkg;

    typedef enum logic [2:0] {
        LFPAX_K_FLAGS_BYTE = 3'h0,
        LFPAX_K_FLAGS_IMM  = 3'h1,
        LFPAX_K_BLOCK_PTR  = 3'h2,
        LFPAX_K_ABS_HALF   = 3'h3,
        LFPAX_K_ABS_WORD   = 3'h4
    } lfpax_kind_type;

    typedef enum logic [1:0] {
        LFPAX_IDLE = 2'h0,
        LFPAX_PH1  = 2'h1,
        LFPAX_PH2  = 2'h2,
        LFPAX_FINAL_PHASE = 2'h3
    } lfpax_phase_type;

    typedef enum logic [1:0] {
        LFPAX_ADD_PASS_D = 2'h0,
        LFPAX_ADD_NEG_D  = 2'h1,
        LFPAX_ADD_PASS_B = 2'h2
    } lfpax_adder_type;

    typedef struct packed {
        lfpax_phase_type phase;
        lfpax_kind_type  kind;
        logic            busy;
        logic [3:0]      rfield;
        logic [31:0]     d_reg;
        logic [31:0]     b_reg;
        logic [16:0]     p_reg;
        logic [31:0]     sum;
        lfpax_adder_type adder;
        logic [3:0]      cc;
        logic            fs;
        logic            fz;
        logic            float_normalize_flag;
        logic [3:0]      rp;
        logic            memory_request_flag;
        logic            data_request_interlock;
        logic            sw7;
        logic            program_addr_in_pc_flag;
        logic            pm_wr_flag;
        logic            ov;
        logic            rel_seen;
        logic            pm_we;
        logic [3:0]      pm_waddr;
        logic [31:0]     pm_wdata;
        logic            trap;
        logic [7:0]      trap_vec;
        logic            done;
        logic [31:0]     pm_rdata;
        logic            rel_s1;
        logic            rel_s2;
        logic            rel_s3;
        logic            arith_mask;
        logic [4:0]      blocks;
        logic [31:0]     rd_data;
        logic [31:0]     psd_low;
    } lfpax_state_type;

endpackage

/* hw/lfpax_exec.sv */
/*
 Execution phases of load-flags (byte and immediate), load-block-pointer,
 load-absolute-halfword and load-absolute-word.
 Assumes the preparation logic gives a one-cycle start with operand, R field and
 program address, and that core memory returns an asynchronous data-release level.
*/
`include "lfpax_defs.svh"

module lfpax_exec (
    // Clock and reset
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst,
    // Instruction start from preparation
    input  wire logic                    i_start,
    input  wire lfpax_pkg::lfpax_kind_type i_kind,
    input  wire logic [3:0]              i_rfield,
    input  wire logic [31:0]             i_operand,
    input  wire logic [31:0]             i_prog_addr,
    // Core memory
    input  wire logic                    i_data_release,
    // Private memory read path
    input  wire logic                    i_pm_rd_stb,
    input  wire logic [31:0]             i_pm_rdata,
    // Register port
    input  wire logic [3:0]              i_addr,
    input  wire logic [31:0]             i_wr_data,
    input  wire logic                    i_wr_stb,
    input  wire logic                    i_rd_stb,
    output logic [31:0]                  o_rd_data,
    // Processor state
    output logic                         o_busy,
    output logic                         o_done,
    output logic [3:0]                   o_cc,
    output logic                         o_float_significance_flag,
    output logic                         o_float_zero_flag,
    output logic                         o_float_normalize_flag,
    output logic [3:0]                   o_register_block_pointer,
    output logic [31:0]                  o_psd_low,
    output logic [16:0]                  o_p_reg,
    output logic [31:0]                  o_sum,
    output lfpax_pkg::lfpax_adder_type   o_adder_mode,
    output logic                         o_memory_request_flag,
    output logic                         o_data_request_interlock,
    output logic                         o_operand_polarity_flag,
    output logic                         o_program_addr_in_pc_flag,
    output logic                         o_pm_write_flag,
    // Private memory write and read result
    output logic                         o_pm_we,
    output logic [3:0]                   o_pm_waddr,
    output logic [31:0]                  o_pm_wdata,
    output logic [31:0]                  o_pm_rdata,
    // Trap
    output logic                         o_trap,
    output logic [7:0]                   o_trap_vector
);
    import lfpax_pkg::*;

    localparam lfpax_state_type ST_RST = '{
        phase      : LFPAX_IDLE,
        kind       : LFPAX_K_FLAGS_BYTE,
        adder      : LFPAX_ADD_PASS_D,
        arith_mask : `LFPAX_RST_MASK,
        blocks     : `LFPAX_RST_BLOCKS,
        default    : '0
    };

    lfpax_state_type s_q;
    lfpax_state_type s_d;
    logic [31:0]     sum_bus;
    logic            rel_pulse;
    logic [31:0]     op_in;

    function automatic logic [31:0] adder_out(
        input lfpax_adder_type mode,
        input logic [31:0]     d,
        input logic [31:0]     b
    );
        logic [31:0] r;
        r = d;
        unique case (mode)
            LFPAX_ADD_PASS_D: r = d;
            LFPAX_ADD_NEG_D:  r = (~d) + 32'h1;
            LFPAX_ADD_PASS_B: r = b;
            default:          r = d;
        endcase
        return r;
    endfunction

    function automatic logic is_abs(input lfpax_kind_type k);
        return (k == LFPAX_K_ABS_HALF) || (k == LFPAX_K_ABS_WORD);
    endfunction

    function automatic logic [31:0] operand_in(
        input lfpax_kind_type k,
        input logic [31:0]    op
    );
        logic [31:0] r;
        r = op;
        unique case (k)
            LFPAX_K_FLAGS_BYTE: r = {24'h0, op[7:0]};
            LFPAX_K_FLAGS_IMM:  r = {{12{op[19]}}, op[19:0]};
            LFPAX_K_BLOCK_PTR:  r = op;
            LFPAX_K_ABS_HALF:   r = {{16{op[15]}}, op[15:0]};
            LFPAX_K_ABS_WORD:   r = op;
            default:            r = op;
        endcase
        return r;
    endfunction

    assign sum_bus   = adder_out(s_q.adder, s_q.d_reg, s_q.b_reg);
    assign op_in     = operand_in(i_kind, i_operand);
    assign rel_pulse = s_q.rel_s2 & ~s_q.rel_s3;

    always_comb begin
        s_d          = s_q;
        s_d.pm_we    = 1'b0;
        s_d.trap     = 1'b0;
        s_d.done     = 1'b0;
        s_d.rd_data  = 32'h0;

        // Data release synchroniser
        s_d.rel_s1 = i_data_release;
        s_d.rel_s2 = s_q.rel_s1;
        s_d.rel_s3 = s_q.rel_s2;
        if (s_q.busy && rel_pulse) begin
            s_d.rel_seen = 1'b1;
        end

        // Register writes
        if (i_wr_stb && (i_addr == `LFPAX_REG_CTRL)) begin
            s_d.arith_mask = i_wr_data[`LFPAX_CTRL_MASK_BIT];
            s_d.blocks     = i_wr_data[`LFPAX_CTRL_BLK_MSB:`LFPAX_CTRL_BLK_LSB];
        end

        // Register reads, data in the next cycle
        if (i_rd_stb) begin
            unique case (i_addr)
                `LFPAX_REG_STATUS: s_d.rd_data = {16'h0, s_q.rp, 1'b0, s_q.fs, s_q.fz,
                                                  s_q.float_normalize_flag, s_q.cc, s_q.busy, s_q.ov,
                                                  s_q.phase};
                `LFPAX_REG_CTRL:   s_d.rd_data = {23'h0, s_q.blocks, 3'h0, s_q.arith_mask};
                `LFPAX_REG_SUM:    s_d.rd_data = s_q.sum;
                default:           s_d.rd_data = 32'h0;
            endcase
        end

        if (i_pm_rd_stb) begin
            s_d.pm_rdata = ({1'b0, s_q.rp} >= s_q.blocks) ? `LFPAX_ALL_ONES : i_pm_rdata;
        end

        unique case (s_q.phase)
            LFPAX_IDLE: begin
                if (i_start) begin
                    s_d.busy     = 1'b1;
                    s_d.kind     = i_kind;
                    s_d.rfield   = i_rfield;
                    s_d.d_reg    = op_in;
                    s_d.b_reg    = i_prog_addr;
                    s_d.ov       = 1'b0;
                    s_d.rel_seen = 1'b0;
                    s_d.phase    = LFPAX_PH1;
                    if (is_abs(i_kind)) begin
                        s_d.sw7   = ~op_in[31];
                        s_d.adder = LFPAX_ADD_PASS_B;
                    end else begin
                        s_d.adder = LFPAX_ADD_PASS_D;
                        s_d.memory_request_flag   = 1'b1;
                    end
                end
            end
            LFPAX_PH1: begin
                s_d.sum = sum_bus;
                if (is_abs(s_q.kind)) begin
                    s_d.p_reg      = sum_bus[16:0];
                    s_d.program_addr_in_pc_flag        = 1'b1;
                    s_d.adder      = s_q.sw7 ? LFPAX_ADD_PASS_D : LFPAX_ADD_NEG_D;
                    s_d.pm_wr_flag = 1'b1;
                    s_d.memory_request_flag        = 1'b1;
                    s_d.phase      = LFPAX_PH2;
                end else begin
                    if (s_q.kind == LFPAX_K_BLOCK_PTR) begin
                        s_d.rp = sum_bus[`LFPAX_S24_27_MSB:`LFPAX_S24_27_LSB];
                    end else begin
                        if (s_q.rfield[`LFPAX_RF_BIT10]) begin
                            s_d.cc = sum_bus[`LFPAX_S24_27_MSB:`LFPAX_S24_27_LSB];
                        end
                        if (s_q.rfield[`LFPAX_RF_BIT11]) begin
                            s_d.fs  = sum_bus[`LFPAX_S29];
                            s_d.fz  = sum_bus[`LFPAX_S30];
                            s_d.float_normalize_flag = sum_bus[`LFPAX_S31];
                        end
                    end
                    s_d.data_request_interlock   = 1'b1;
                    s_d.phase = LFPAX_FINAL_PHASE;
                end
            end
            LFPAX_PH2: begin
                s_d.sum        = sum_bus;
                s_d.pm_we      = 1'b1;
                s_d.pm_waddr   = s_q.rfield;
                s_d.pm_wdata   = sum_bus;
                s_d.pm_wr_flag = 1'b0;
                s_d.ov = (s_q.kind == LFPAX_K_ABS_WORD) &&
                         (s_q.d_reg == `LFPAX_MOST_NEG);
                s_d.cc[2] = (s_q.kind == LFPAX_K_ABS_WORD) &&
                            (s_q.d_reg == `LFPAX_MOST_NEG);
                s_d.cc[1] = |sum_bus;
                s_d.cc[0] = 1'b0;
                s_d.data_request_interlock   = 1'b1;
                s_d.phase = LFPAX_FINAL_PHASE;
            end
            LFPAX_FINAL_PHASE: begin
                if (rel_pulse || s_q.rel_seen) begin
                    s_d.data_request_interlock      = 1'b0;
                    s_d.memory_request_flag      = 1'b0;
                    s_d.program_addr_in_pc_flag      = 1'b0;
                    s_d.rel_seen = 1'b0;
                    s_d.busy     = 1'b0;
                    s_d.done     = 1'b1;
                    s_d.phase    = LFPAX_IDLE;
                    if (s_q.ov && s_q.arith_mask) begin
                        s_d.trap     = 1'b1;
                        s_d.trap_vec = `LFPAX_TRAP_VECTOR;
                    end
                end
            end
        endcase

        s_d.psd_low = {24'h0, s_d.rp, 4'h0};
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rd_data                 = s_q.rd_data;
    assign o_busy                    = s_q.busy;
    assign o_done                    = s_q.done;
    assign o_cc                      = s_q.cc;
    assign o_float_significance_flag = s_q.fs;
    assign o_float_zero_flag         = s_q.fz;
    assign o_float_normalize_flag    = s_q.float_normalize_flag;
    assign o_register_block_pointer  = s_q.rp;
    assign o_psd_low                 = s_q.psd_low;
    assign o_p_reg                   = s_q.p_reg;
    assign o_sum                     = s_q.sum;
    assign o_adder_mode              = s_q.adder;
    assign o_memory_request_flag     = s_q.memory_request_flag;
    assign o_data_request_interlock  = s_q.data_request_interlock;
    assign o_operand_polarity_flag   = s_q.sw7;
    assign o_program_addr_in_pc_flag = s_q.program_addr_in_pc_flag;
    assign o_pm_write_flag           = s_q.pm_wr_flag;
    assign o_pm_we                   = s_q.pm_we;
    assign o_pm_waddr                = s_q.pm_waddr;
    assign o_pm_wdata                = s_q.pm_wdata;
    assign o_pm_rdata                = s_q.pm_rdata;
    assign o_trap                    = s_q.trap;
    assign o_trap_vector             = s_q.trap_vec;

endmodule // lfpax_exec

/* verif/lfpax_exec_properties.sv */
/*
 Port checker of the execution block.
 Assumes a bind to lfpax_exec from the bench top.
*/
module lfpax_exec_chk (
    // Clock, reset and start
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_start,
    input wire lfpax_pkg::lfpax_kind_type i_kind,
    input wire logic [3:0]  i_rfield,
    input wire logic [31:0] i_operand,
    input wire logic [31:0] i_prog_addr,
    // Processor state
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic [3:0]  o_cc,
    input wire logic        o_float_significance_flag,
    input wire logic        o_float_zero_flag,
    input wire logic        o_float_normalize_flag,
    input wire logic [3:0]  o_register_block_pointer,
    input wire logic [31:0] o_psd_low,
    input wire logic [16:0] o_p_reg,
    input wire lfpax_pkg::lfpax_adder_type o_adder_mode,
    input wire logic        o_memory_request_flag,
    input wire logic        o_data_request_interlock,
    input wire logic        o_program_addr_in_pc_flag,
    input wire logic        o_pm_write_flag,
    input wire logic        o_operand_polarity_flag,
    input wire logic [31:0] o_sum,
    // Register write and trap
    input wire logic        o_pm_we,
    input wire logic [3:0]  o_pm_waddr,
    input wire logic [31:0] o_pm_wdata,
    input wire logic        o_trap,
    input wire logic [7:0]  o_trap_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    import lfpax_pkg::*;
    logic        go;
    logic        neg;
    logic [2:0]  modes;
    logic [31:0] sx;
    logic [31:0] dv;
    assign go = i_start && !o_busy;
    assign neg = (i_kind == LFPAX_K_ABS_HALF) ? i_operand[15] : i_operand[31];
    assign sx = (i_kind == LFPAX_K_ABS_HALF) ? {{16{i_operand[15]}}, i_operand[15:0]} : i_operand;
    assign modes = {o_float_significance_flag, o_float_zero_flag, o_float_normalize_flag};
    assign dv = (i_kind == LFPAX_K_FLAGS_BYTE) ? {24'h0, i_operand[7:0]} :
                (i_kind == LFPAX_K_FLAGS_IMM) ? {{12{i_operand[19]}}, i_operand[19:0]} :
                i_operand;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_pass_b;
        o_adder_mode == LFPAX_ADD_PASS_B;
    endsequence
    sequence s_addr_in_pc;
        o_program_addr_in_pc_flag && o_pm_write_flag && o_memory_request_flag
            && o_p_reg == $past(i_prog_addr[16:0], 2);
    endsequence
    a_start_request: assert property (
        go && i_kind <= LFPAX_K_BLOCK_PTR |=> o_memory_request_flag) else $error("no request");
    a_cc_load: assert property (go && i_kind <= LFPAX_K_FLAGS_IMM |-> ##2
        o_cc == ($past(i_rfield[1], 2) ? $past(i_operand[7:4], 2) : $past(o_cc)))
        else $error("flags wrong");
    a_mode_load: assert property (go && i_kind <= LFPAX_K_FLAGS_IMM |-> ##2
        modes == ($past(i_rfield[0], 2) ? $past(i_operand[2:0], 2) : $past(modes)))
        else $error("modes wrong");
    a_ptr_load: assert property (go && i_kind == LFPAX_K_BLOCK_PTR |-> ##2
        o_register_block_pointer == $past(i_operand[7:4], 2)
        && o_psd_low == {24'h0, $past(i_operand[7:4], 2), 4'h0}) else $error("pointer wrong");
    a_final_wait: assert property (go && i_kind <= LFPAX_K_BLOCK_PTR |-> ##2
        o_data_request_interlock && !o_done) else $error("no interlock");
    a_abs_steps: assert property (go && i_kind >= LFPAX_K_ABS_HALF |=>
        s_pass_b ##1 s_addr_in_pc) else $error("abs first phase wrong");
    a_adder_sign: assert property (go && i_kind >= LFPAX_K_ABS_HALF |-> ##2
        o_adder_mode == ($past(neg, 2) ? LFPAX_ADD_NEG_D : LFPAX_ADD_PASS_D))
        else $error("adder preset wrong");
    a_abs_write: assert property (go && i_kind >= LFPAX_K_ABS_HALF |-> ##3
        o_pm_we && o_pm_waddr == $past(i_rfield, 3)
        && o_pm_wdata == ($past(neg, 3) ? -$past(sx, 3) : $past(sx, 3))) else $error("abs write");
    a_abs_flags: assert property (go && i_kind >= LFPAX_K_ABS_HALF |-> ##3
        o_cc[1:0] == {$past(sx, 3) != 32'h0, 1'b0}) else $error("abs flags wrong");
    a_polarity_store: assert property (go && i_kind >= LFPAX_K_ABS_HALF |=>
        o_operand_polarity_flag == !$past(neg)) else $error("polarity flag wrong");
    a_sum_pass_b: assert property (go && i_kind >= LFPAX_K_ABS_HALF |-> ##2
        o_sum == $past(i_prog_addr, 2)) else $error("program address sum wrong");
    a_sum_pass_d: assert property (go && i_kind <= LFPAX_K_BLOCK_PTR |-> ##2
        o_sum == $past(dv, 2)) else $error("data sum wrong");
    a_word_ovf: assert property (go && i_kind == LFPAX_K_ABS_WORD |-> ##3
        o_cc[2] == ($past(i_operand, 3) == 32'h80000000)) else $error("overflow flag wrong");
    a_trap_vec: assert property (o_trap |-> o_done ##1 o_trap_vector == 8'h43)
        else $error("trap wrong");
endmodule // lfpax_exec_chk

/* verif/lfpax_mem_model.sv */
/*
 Core memory release and private register file model.
 Assumes the block's request flag and register write port.
*/
module lfpax_mem_model (
    // Clock and release delay
    input  wire logic        i_clk_sys,
    input  wire logic [3:0]  i_delay,
    // Block side
    input  wire logic        i_mrq,
    input  wire logic        i_we,
    input  wire logic [3:0]  i_waddr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_raddr,
    output logic             o_release,
    output logic [31:0]      o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs_q [16];
    logic [3:0]  wait_q = 4'h0;
    logic        rel_q = 1'b0;
    assign o_release = rel_q;
    assign o_rdata = regs_q[i_raddr];
    // Release a set time after request
    always @(posedge i_clk_sys) begin
        wait_q <= !i_mrq ? 4'h0 : (wait_q == 4'hf ? wait_q : wait_q + 4'h1);
        rel_q <= i_mrq && wait_q >= i_delay;
        if (i_we)
            regs_q[i_waddr] <= i_wdata;
    end
endmodule // lfpax_mem_model

/* verif/load_flags_pointer_absolute_exec_tb_top.sv */
/*
 Testbench of the execution block.
 Assumes the package, the block, its checker and memory model compiled first.
*/
module load_flags_pointer_absolute_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lfpax_pkg::*;
    logic           i_clk_sys = 1'b0;
    logic           i_rst = 1'b1;
    logic           i_start = 1'b0;
    lfpax_kind_type i_kind = LFPAX_K_FLAGS_BYTE;
    logic [3:0]     i_rfield = 4'h0;
    logic [3:0]     i_addr = 4'h0;
    logic [3:0]     pm_raddr = 4'h0;
    logic [3:0]     delay = 4'h1;
    logic [31:0]    i_operand = 32'h0;
    logic [31:0]    i_prog_addr = 32'h0;
    logic [31:0]    i_wr_data = 32'h0;
    logic           i_pm_rd_stb = 1'b0;
    logic           i_wr_stb = 1'b0;
    logic           i_rd_stb = 1'b0;
    logic           i_data_release;
    logic [31:0]    i_pm_rdata;
    logic [31:0]    o_rd_data, o_psd_low, o_pm_wdata, o_pm_rdata, rd_val, last_w;
    logic [3:0]     o_cc, o_register_block_pointer, o_pm_waddr;
    logic [7:0]     o_trap_vector;
    logic           o_done, o_float_significance_flag, o_float_zero_flag;
    logic           o_float_normalize_flag, o_memory_request_flag, o_pm_we, o_trap;
    int             n_fail = 0;
    int             check_count = 0;
    int             n_trap = 0;
    int             cycles = 0;

    lfpax_exec i_dut (
        .i_clk_sys, .i_rst, .i_start, .i_kind, .i_rfield, .i_operand, .i_prog_addr,
        .i_data_release, .i_pm_rd_stb, .i_pm_rdata, .i_addr, .i_wr_data, .i_wr_stb,
        .i_rd_stb, .o_rd_data, .o_busy(), .o_done, .o_cc, .o_float_significance_flag,
        .o_float_zero_flag, .o_float_normalize_flag, .o_register_block_pointer, .o_psd_low,
        .o_p_reg(), .o_sum(), .o_adder_mode(), .o_memory_request_flag,
        .o_data_request_interlock(), .o_operand_polarity_flag(), .o_program_addr_in_pc_flag(),
        .o_pm_write_flag(), .o_pm_we, .o_pm_waddr, .o_pm_wdata, .o_pm_rdata, .o_trap,
        .o_trap_vector);
    lfpax_mem_model i_mem (
        .i_clk_sys, .i_delay(delay), .i_mrq(o_memory_request_flag), .i_we(o_pm_we),
        .i_waddr(o_pm_waddr), .i_wdata(o_pm_wdata), .i_raddr(pm_raddr),
        .o_release(i_data_release), .o_rdata(i_pm_rdata));

    always #12.5 i_clk_sys = ~i_clk_sys;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Monitor writes, traps and run length
    always @(negedge i_clk_sys) begin
        cycles++;
        if (o_pm_we === 1'b1)
            last_w = o_pm_wdata;
        if (o_trap === 1'b1)
            n_trap++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr_stb <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr_stb <= 1'b0;
    endtask

    task automatic rd(input bit pm, input logic [3:0] a);
        @(posedge i_clk_sys);
        i_rd_stb <= !pm;
        i_pm_rd_stb <= pm;
        i_addr <= a;
        pm_raddr <= a;
        @(posedge i_clk_sys);
        i_rd_stb <= 1'b0;
        i_pm_rd_stb <= 1'b0;
        #1;
        rd_val = pm ? o_pm_rdata : o_rd_data;
    endtask

    task automatic run(input lfpax_kind_type k, input logic [3:0] rf, input logic [31:0] op);
        int n;
        @(posedge i_clk_sys);
        i_start <= 1'b1;
        i_kind <= k;
        i_rfield <= rf;
        i_operand <= op;
        i_prog_addr <= ~op;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        for (n = 0; n < 100 && o_done !== 1'b1; n++) begin
            @(posedge i_clk_sys);
            #1;
        end
        check("done", 32'h1, {31'h0, o_done});
    endtask

    task automatic flags(input logic [3:0] c, input logic [2:0] f);
        check("cc", {28'h0, c}, {28'h0, o_cc});
        check("modes", {29'h0, f},
            {29'h0, o_float_significance_flag, o_float_zero_flag, o_float_normalize_flag});
    endtask

    task automatic absx(input lfpax_kind_type k, input logic [31:0] op, input logic [31:0] w);
        run(k, 4'h6, op);
        check("abs", w, last_w);
        check("cc", {29'h0, 1'b0, w != 32'h0, 1'b0}, {29'h0, o_cc[2:0]});
    endtask

    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(1'b0, 4'h4);
        check("ctrl", 32'h100, rd_val);
        rd(1'b0, 4'hc);
        check("unmapped", 32'h0, rd_val);
        run(LFPAX_K_FLAGS_BYTE, 4'h3, 32'ha5);
        flags(4'ha, 3'h5);
        run(LFPAX_K_FLAGS_BYTE, 4'h0, 32'h5a);
        flags(4'ha, 3'h5);
        run(LFPAX_K_FLAGS_IMM, 4'h2, 32'hfffff036);
        flags(4'h3, 3'h5);
        delay <= 4'hc;
        run(LFPAX_K_FLAGS_IMM, 4'h1, 32'h2);
        flags(4'h3, 3'h2);
        delay <= 4'h1;
        run(LFPAX_K_BLOCK_PTR, 4'h0, 32'hc0);
        check("pointer", 32'hc, {28'h0, o_register_block_pointer});
        check("psd", 32'hc0, o_psd_low);
        absx(LFPAX_K_ABS_HALF, 32'hffee, 32'h12);
        rd(1'b1, 4'h6);
        check("present", 32'h12, rd_val);
        wr(4'h4, 32'h80);
        rd(1'b1, 4'h6);
        check("absent", 32'hffffffff, rd_val);
        absx(LFPAX_K_ABS_HALF, 32'h0, 32'h0);
        absx(LFPAX_K_ABS_WORD, 32'hfffffff0, 32'h10);
        absx(LFPAX_K_ABS_WORD, 32'h7fffffff, 32'h7fffffff);
        run(LFPAX_K_ABS_WORD, 4'h6, 32'h80000000);
        check("overflow", 32'h1, {31'h0, o_cc[2]});
        wr(4'h4, 32'h81);
        check("no trap", 32'h0, n_trap);
        rd(1'b0, 4'h4);
        check("ctrl", 32'h81, rd_val);
        run(LFPAX_K_ABS_WORD, 4'h6, 32'h80000000);
        absx(LFPAX_K_ABS_WORD, 32'h1, 32'h1);
        check("trap", 32'h1, n_trap);
        check("vector", 32'h43, {24'h0, o_trap_vector});
        rd(1'b0, 4'h0);
        check("status", 32'hc220, rd_val);
        rd(1'b0, 4'h8);
        check("sum", 32'h1, rd_val);
        print_verdict();
    end
endmodule // load_flags_pointer_absolute_exec_tb_top

bind lfpax_exec lfpax_exec_chk i_chk (
    .i_clk_sys, .i_rst, .i_start, .i_kind, .i_rfield, .i_operand, .i_prog_addr, .o_busy,
    .o_done, .o_cc, .o_float_significance_flag, .o_float_zero_flag, .o_float_normalize_flag,
    .o_register_block_pointer, .o_psd_low, .o_p_reg, .o_adder_mode, .o_memory_request_flag,
    .o_data_request_interlock, .o_program_addr_in_pc_flag, .o_pm_write_flag,
    .o_operand_polarity_flag, .o_sum, .o_pm_we,
    .o_pm_waddr, .o_pm_wdata, .o_trap, .o_trap_vector);
